// >>> rtl/kwd_pkg.sv
`default_nettype none

package kwd_pkg;

  // ---------------------------------------------------------------
  // counter and timing
  // ---------------------------------------------------------------
  localparam int CNT_W = 22;
  localparam logic [21:0] CNT_MAX = 22'h3fffff;
  localparam int PRE_LSB = 15;
  localparam logic [3:0] MCYC_LAST = 4'hb;
  localparam int OSC_PER_MCYC = 12;
  // pulse length in oscillator periods; clk_sys is the oscillator
  localparam int RST_PULSE_OSC = OSC_PER_MCYC * (2 ** 15);
  localparam int CLK_PER_OSC = 1;
  localparam int RST_PULSE_CYC = RST_PULSE_OSC * CLK_PER_OSC;
  localparam int PULSE_W = 20;

  // ---------------------------------------------------------------
  // register map: printed offsets are indices, byte address = 4x
  // ---------------------------------------------------------------
  localparam logic [7:0] SVC_IDX = 8'ha6;
  localparam logic [7:0] KEY_IDX = 8'hae;
  localparam logic [7:0] STAT_IDX = 8'hb0;
  localparam logic [7:0] MASK_IDX = 8'hb1;
  localparam logic [7:0] CNT_IDX = 8'hb2;
  localparam logic [7:0] SVC_BAD_MIN = 8'h7f;
  localparam logic [7:0] KEY_DISABLE = 8'h55;
  localparam logic [7:0] KEY_RESET = 8'h00;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam int ST_OVF = 0;
  localparam int ST_BAD = 1;
  localparam int ST_W = 2;

  typedef enum logic {BUS_IDLE, BUS_ACT} kwd_bus_e;

  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
  } kwd_ahb_req_s;

  typedef struct packed {
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
  } kwd_ahb_rsp_s;

  typedef struct packed {
    kwd_bus_e st;
    logic [7:0] idx;
    logic wr;
    logic hit;
    logic ready;
    logic [31:0] rdata;
    logic [3:0] div;
    logic [21:0] cnt;
    logic [7:0] key;
    logic [19:0] pulse;
    logic rst_out;
    logic [1:0] stat;
    logic [1:0] mask;
    logic irq;
  } kwd_state_s;

endpackage : kwd_pkg

`default_nettype wire

// >>> rtl/kwd_top.sv
// The AHB-Lite slave port was decided locally.
`default_nettype none

module kwd_top
  import kwd_pkg::*;
#(
  parameter int RST_PULSE = RST_PULSE_CYC,
  // overflow point; lowered only so short runs can reach a reset
  parameter logic [21:0] OVF_AT = CNT_MAX
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // register bus
  input wire kwd_ahb_req_s ahb_req,
  output kwd_ahb_rsp_s ahb_rsp,
  // reset and interrupt out
  output logic wdt_rst,
  output logic wdt_rst_n,
  output logic wdt_irq
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  kwd_state_s q;
  kwd_state_s d;
  logic tick;
  logic acc;
  logic wr_go;
  logic svc_wr;
  logic svc_ok;
  logic svc_bad;
  logic wd_en;
  logic ovf;
  logic [1:0] st_clr;
  logic [1:0] st_set;
  logic [31:0] rd_mux;

  localparam logic [19:0] PULSE_LAST = PULSE_W'(RST_PULSE - 1);

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    d = q;
    // machine cycle is twelve oscillator periods
    tick = (q.div == MCYC_LAST);
    d.div = tick ? 4'h0 : 4'(q.div + 4'h1);

    acc = ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready;
    wr_go = (q.st == BUS_ACT) && q.wr && q.hit;
    svc_wr = wr_go && (q.idx == SVC_IDX);
    svc_ok = svc_wr && (ahb_req.hwdata[7:0] < SVC_BAD_MIN);
    svc_bad = svc_wr && !svc_ok;
    wd_en = (q.key != KEY_DISABLE);
    // overflow is judged on the old count; a service in the same
    // cycle wins because software got there first
    ovf = tick && wd_en && !q.rst_out && !svc_ok
      && (q.cnt == OVF_AT);

    // no idle input: the counter never looks at cpu sleep state
    // held at zero from the overflow itself through the whole pulse
    if (q.rst_out || ovf) begin
      d.cnt = '0;
    end else if (svc_ok) begin
      d.cnt = {ahb_req.hwdata[6:0], 15'h0000};
    end else if (tick && wd_en) begin
      d.cnt = 22'(q.cnt + 22'h1);
    end

    if (ovf) begin
      d.rst_out = 1'b1;
      d.pulse = PULSE_LAST;
      d.key = KEY_RESET;
    end else if (q.rst_out) begin
      if (q.pulse == '0) begin
        d.rst_out = 1'b0;
      end else begin
        d.pulse = 20'(q.pulse - 20'h1);
      end
    end

    if (wr_go && (q.idx == KEY_IDX) && !ovf) begin
      d.key = ahb_req.hwdata[7:0];
    end

    // sticky events; a set in the clearing cycle survives
    st_set = '0;
    st_set[ST_OVF] = ovf;
    st_set[ST_BAD] = svc_bad;
    st_clr = '0;
    if (wr_go && (q.idx == STAT_IDX)) begin
      st_clr = ahb_req.hwdata[ST_W-1:0];
    end
    d.stat = (q.stat & ~st_clr) | st_set;
    if (wr_go && (q.idx == MASK_IDX)) begin
      d.mask = ahb_req.hwdata[ST_W-1:0];
    end
    d.irq = |(d.stat & d.mask);

    // read mux; the service register is write only
    rd_mux = '0;
    if (!q.hit) begin
      rd_mux = '0;
    end else if (q.idx == KEY_IDX) begin
      rd_mux[7:0] = q.key;
    end else if (q.idx == STAT_IDX) begin
      rd_mux[ST_W-1:0] = q.stat;
    end else if (q.idx == MASK_IDX) begin
      rd_mux[ST_W-1:0] = q.mask;
    end else if (q.idx == CNT_IDX) begin
      rd_mux[CNT_W-1:0] = q.cnt;
    end

    // one wait state keeps read-after-write coherent
    case (q.st)
      BUS_IDLE: begin
        if (acc) begin
          d.st = BUS_ACT;
          d.ready = 1'b0;
          d.idx = ahb_req.haddr[9:2];
          d.wr = ahb_req.hwrite;
          d.hit = (ahb_req.haddr[31:10] == '0)
            && (ahb_req.haddr[1:0] == 2'h0)
            && (ahb_req.hsize == HSIZE_WORD);
        end
      end
      BUS_ACT: begin
        d.st = BUS_IDLE;
        d.ready = 1'b1;
        if (!q.wr) begin
          d.rdata = rd_mux;
        end
      end
      default: begin
        d.st = BUS_IDLE;
        d.ready = 1'b1;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{st: BUS_IDLE, idx: 8'h00, wr: 1'b0, hit: 1'b0,
             ready: 1'b1, rdata: 32'h0000_0000, div: 4'h0,
             cnt: 22'h000000, key: KEY_RESET, pulse: 20'h00000,
             rst_out: 1'b0, stat: 2'h0, mask: 2'h0, irq: 1'b0};
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign ahb_rsp.hreadyout = q.ready;
  assign ahb_rsp.hresp = 1'b0;
  assign ahb_rsp.hrdata = q.rdata;
  assign wdt_rst = q.rst_out;
  assign wdt_rst_n = !q.rst_out;
  assign wdt_irq = q.irq;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  logic [19:0] hi_len_q;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hi_len_q <= 20'h00000;
    end else if (q.rst_out) begin
      hi_len_q <= 20'(hi_len_q + 20'h1);
    end else begin
      hi_len_q <= 20'h00000;
    end
  end

  a_tick_period: assert property (tick |-> ##12 tick)
    else $error("machine cycle tick not every twelve clocks");

  a_count_step: assert property (
    (tick && wd_en && !svc_ok && !q.rst_out && q.cnt != OVF_AT)
    |=> q.cnt == 22'($past(q.cnt) + 22'h1))
    else $error("counter did not advance on machine cycle");

  a_ovf_reset: assert property (
    (tick && wd_en && !svc_ok && !q.rst_out && q.cnt == OVF_AT)
    |=> wdt_rst && !wdt_rst_n && q.cnt == '0)
    else $error("overflow did not raise reset");

  a_pulse_len: assert property (
    $fell(q.rst_out) |-> hi_len_q == PULSE_W'(RST_PULSE))
    else $error("reset pulse length wrong");

  a_key_halt: assert property (
    (q.key == KEY_DISABLE && !svc_ok && !q.rst_out && !wr_go)
    |=> $stable(q.cnt))
    else $error("counter moved while disabled");

  a_enable_after: assert property (
    $rose(q.rst_out) |-> q.key == KEY_RESET)
    else $error("watchdog left disabled after its reset");

  a_svc_load: assert property (
    (svc_ok && !q.rst_out) |=> q.cnt[21:15] == $past(ahb_req.hwdata[6:0])
    && q.cnt[14:0] == 15'h0000)
    else $error("service preload not loaded");

  a_svc_zero: assert property (
    (svc_ok && !q.rst_out && ahb_req.hwdata[6:0] == 7'h00)
    |=> q.cnt == '0)
    else $error("zero service did not clear counter");

  a_svc_bad: assert property (
    (svc_bad && !q.rst_out && !ovf) |=> q.stat[ST_BAD]
    && (q.cnt == $past(q.cnt) || q.cnt == 22'($past(q.cnt) + 22'h1)))
    else $error("invalid service changed counter");

  a_irq_level: assert property (
    wdt_irq == |(q.stat & q.mask))
    else $error("interrupt level does not follow status");

  a_irq_on_ovf: assert property (
    (ovf && q.mask[ST_OVF]) |=> wdt_irq)
    else $error("unmasked overflow did not raise interrupt");

  a_bus_wait: assert property (
    (q.st == BUS_IDLE && acc) |=> !ahb_rsp.hreadyout ##1 ahb_rsp.hreadyout)
    else $error("bus answer not after one wait state");

endmodule : kwd_top

`default_nettype wire

// >>> testbench/tb.sv
`default_nettype none

module tb;
  import kwd_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk_sys;
  logic rst_n;
  kwd_ahb_req_s ahb_req;
  kwd_ahb_rsp_s ahb_rsp;
  logic wdt_rst;
  logic wdt_rst_n;
  logic wdt_irq;
  int miscompares;
  int checked;
  logic [31:0] rd;
  logic [31:0] c1;

  int cyc;
  // short pulse and a low overflow point keep the reset path in reach
  localparam int PULSE_TB = 16;
  localparam logic [21:0] OVF_TB = 22'h3f0040;

  kwd_top #(.RST_PULSE(PULSE_TB), .OVF_AT(OVF_TB)) i_kwd_top (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    // bus hready is the one slave's hreadyout
    .ahb_req({ahb_req[$bits(kwd_ahb_req_s)-1:1], ahb_rsp.hreadyout}),
    .ahb_rsp(ahb_rsp),
    .wdt_rst(wdt_rst),
    .wdt_rst_n(wdt_rst_n),
    .wdt_irq(wdt_irq)
  );

  // ---------------------------------------------------------------
  // closing, compares, bus cycles
  // ---------------------------------------------------------------
  task automatic end_sim();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    checked++;
    if (!((got >= lo) === 1'b1 && (got <= hi) === 1'b1)) begin
      miscompares++;
      $display("mismatch at %0t: got %h want %h..%h", $time, got, lo, hi);
    end
  endtask : chk

  // hready judged at the rising edge, where the slave's answer counts
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
      if (n > 20) begin
        miscompares++;
        end_sim();
      end
    end while (ahb_rsp.hreadyout !== 1'b1);
  endtask : wait_rdy

  // called right after a rising edge; leaves htrans idle, so no release
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    ahb_req.hsel <= 1'b1;
    ahb_req.haddr <= {22'h0, idx, 2'b00};
    ahb_req.htrans <= 2'b10;
    ahb_req.hwrite <= w;
    ahb_req.hsize <= HSIZE_WORD;
    wait_rdy();
    ahb_req.htrans <= 2'b00;
    ahb_req.hwdata <= wd;
    wait_rdy();
    rd = ahb_rsp.hrdata;
  endtask : xfer

  task automatic irq_is(input logic exp);
    repeat (2) @(negedge clk_sys);
    chk({31'h0, wdt_irq}, {31'h0, exp}, {31'h0, exp});
    @(posedge clk_sys);
  endtask : irq_is

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  initial begin
    rst_n = 1'b0;
    ahb_req = '0;
    miscompares = 0;
    checked = 0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (36) @(posedge clk_sys);
    xfer(1'b0, CNT_IDX, 32'h0);
    chk(rd, 32'h2, 32'h4);
    xfer(1'b0, KEY_IDX, 32'h0);
    chk(rd, 32'h0, 32'h0);
    xfer(1'b1, SVC_IDX, 32'h7e);
    xfer(1'b0, CNT_IDX, 32'h0);
    chk(rd, 32'h3f0000, 32'h3f0001);
    xfer(1'b1, KEY_IDX, 32'h55);
    xfer(1'b0, CNT_IDX, 32'h0);
    c1 = rd;
    repeat (120) @(posedge clk_sys);
    xfer(1'b0, CNT_IDX, 32'h0);
    chk(rd, c1, c1);
    xfer(1'b0, KEY_IDX, 32'h0);
    chk(rd, 32'h55, 32'h55);
    xfer(1'b1, KEY_IDX, 32'haa);
    xfer(1'b0, CNT_IDX, 32'h0);
    c1 = rd;
    // 123 clocks between the two reads: 10 or 11 machine cycles
    repeat (120) @(posedge clk_sys);
    xfer(1'b0, CNT_IDX, 32'h0);
    chk(rd, c1 + 32'd10, c1 + 32'd11);
    xfer(1'b1, SVC_IDX, 32'h0);
    xfer(1'b0, CNT_IDX, 32'h0);
    chk(rd, 32'h0, 32'h1);
    xfer(1'b1, SVC_IDX, 32'h10);
    xfer(1'b1, SVC_IDX, 32'h7f);
    xfer(1'b0, CNT_IDX, 32'h0);
    chk(rd, 32'h080000, 32'h080001);
    xfer(1'b0, STAT_IDX, 32'h0);
    chk(rd, 32'h2, 32'h2);
    irq_is(1'b0);
    xfer(1'b1, MASK_IDX, 32'h2);
    irq_is(1'b1);
    xfer(1'b1, STAT_IDX, 32'h2);
    irq_is(1'b0);
    xfer(1'b0, STAT_IDX, 32'h0);
    chk(rd, 32'h0, 32'h0);
    xfer(1'b0, SVC_IDX, 32'h0);
    chk(rd, 32'h0, 32'h0);
    xfer(1'b0, 8'h01, 32'h0);
    chk(rd, 32'h0, 32'h0);
    chk({30'h0, wdt_rst, wdt_rst_n}, 32'h1, 32'h1);
    // run from a short preload into the overflow point
    xfer(1'b1, MASK_IDX, 32'h1);
    xfer(1'b1, KEY_IDX, 32'h33);
    xfer(1'b1, SVC_IDX, 32'h7e);
    cyc = 0;
    while (wdt_rst !== 1'b1) begin
      @(posedge clk_sys);
      cyc++;
      if (cyc > 2000) begin
        miscompares++;
        end_sim();
      end
    end
    chk({30'h0, wdt_rst, wdt_rst_n}, 32'h2, 32'h2);
    cyc = 0;
    while (wdt_rst === 1'b1 && cyc < 100) begin
      @(posedge clk_sys);
      cyc++;
    end
    chk(cyc, PULSE_TB, PULSE_TB);
    xfer(1'b0, STAT_IDX, 32'h0);
    chk(rd, 32'h1, 32'h1);
    irq_is(1'b1);
    xfer(1'b0, KEY_IDX, 32'h0);
    chk(rd, 32'h0, 32'h0);
    xfer(1'b0, CNT_IDX, 32'h0);
    chk(rd, 32'h0, 32'h2);
    // a reset in mid-run must re-enable a disabled watchdog
    xfer(1'b1, KEY_IDX, 32'h55);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    xfer(1'b0, KEY_IDX, 32'h0);
    chk(rd, 32'h0, 32'h0);
    xfer(1'b0, STAT_IDX, 32'h0);
    chk(rd, 32'h0, 32'h0);
    end_sim();
  end
endmodule : tb

`default_nettype wire
